// ---- src/acop_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the block.
// Assumes inclusion by bare name from files that use these macros.
`ifndef ACOP_CFG_SVH
`define ACOP_CFG_SVH

// Register byte offsets on the Wishbone slave
`define ACOP_OFF_CTRL 5'h00
`define ACOP_OFF_STAT 5'h04
`define ACOP_OFF_IRQ_STAT 5'h08
`define ACOP_OFF_IRQ_MASK 5'h0c
`define ACOP_OFF_LAST_WORD 5'h10

// Field positions
`define ACOP_CTRL_CAL_BIT 0
`define ACOP_STAT_CALIB_BIT 0
`define ACOP_STAT_DONE_BIT 1
`define ACOP_STAT_FULL_BIT 2
`define ACOP_IRQ_CAL_END_BIT 0
`define ACOP_IRQ_OVR_BIT 1
`define ACOP_LAST_OVR_BIT 14

// Reset values
`define ACOP_CTRL_RST 1'h0
`define ACOP_MASK_RST 2'h0

// Timing counts in converter clock cycles
`define ACOP_PIPE_DEPTH 4
`define ACOP_CAL_CYCLES 17400

`endif

// ---- src/acop_pkg.sv ----
// Types shared by the converter control and output port block.
// Assumes acop_cfg.svh for numeric constants.
package acop_pkg;

    // One conversion result with its over-range flag
    typedef struct packed {
        logic over;
        logic [13:0] data;
    } acop_word_t;

    // Calibration control states, Gray along normal -> cal -> normal
    typedef enum logic [1:0] {
        ACOP_NORMAL = 2'h0,
        ACOP_CALIB = 2'h1
    } acop_state_t;

    // Three-stage pin synchroniser with agreement filter
    typedef struct packed {
        logic [2:0] sync;
        logic level;
    } acop_pin_t;

endpackage

// ---- src/acop_top.sv ----
// Converter control: calibration sequencing, 4-deep result pipeline,
// three-state output port with data-valid clock, Wishbone slave, irq.
// Assumes conv_clk_i, cal_request_i and out_enable_i are asynchronous
// pins; raw_word_i comes from the quantizer logic on clk_i.
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
`include "acop_cfg.svh"

// Summary of operation
// - Request low converts normally; driving it high starts calibration.
// - Done output low during calibration, high in normal conversion.
// - Output enable low floats data and flag; high drives them all.
// - Data-valid clock output lets outside logic latch each word.
// - Each output word carries an over-range flag bit beside it.
// - Each word appears four sampling periods after its sample.
// - Calibration lasts 17,400 converter clock cycles before normal mode.
module acop_top #(
    parameter int CAL_CYCLES = `ACOP_CAL_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conv_clk_i,
    input wire logic cal_request_i,
    input wire logic out_enable_i,
    input wire acop_pkg::acop_word_t raw_word_i,
    output logic [13:0] sample_word_o,
    output logic [13:0] sample_word_oe_n_o,
    output logic over_range_flag_o,
    output logic over_range_flag_oe_n_o,
    output logic word_valid_clk_o,
    output logic cal_done_o,
    output logic irq_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    localparam int PD = `ACOP_PIPE_DEPTH;

    acop_pkg::acop_pin_t ck_r, ck_nxt;
    acop_pkg::acop_pin_t rq_r, rq_nxt;
    acop_pkg::acop_pin_t oe_r, oe_nxt;
    acop_pkg::acop_state_t state_r, state_nxt;
    acop_pkg::acop_word_t pipe_r [PD], pipe_nxt [PD];
    acop_pkg::acop_word_t out_r, out_nxt;
    logic [14:0] cal_cnt_r, cal_cnt_nxt;
    logic [2:0] fill_r, fill_nxt;
    logic req_prev_r, req_prev_nxt;
    logic dav_r, dav_nxt;
    logic ctrl_cal_r, ctrl_cal_nxt;
    logic [1:0] irq_stat_r, irq_stat_nxt;
    logic [1:0] irq_mask_r, irq_mask_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic ck_rise, ck_fall, req_now, wr_hit, cal_end;
    logic [1:0] irq_set;

    // Pin synchronisers: three flops, level follows when stages 2 and 3 agree
    function automatic acop_pkg::acop_pin_t pin_step(
        input acop_pkg::acop_pin_t p,
        input logic pin
    );
        acop_pkg::acop_pin_t n;
        n.sync = {p.sync[1:0], pin};
        n.level = (p.sync[1] == p.sync[2]) ? p.sync[2] : p.level;
        return n;
    endfunction

    // Edge and event decode
    always_comb begin
        ck_nxt = pin_step(ck_r, conv_clk_i);
        rq_nxt = pin_step(rq_r, cal_request_i);
        oe_nxt = pin_step(oe_r, out_enable_i);
        ck_rise = ck_nxt.level & ~ck_r.level;
        ck_fall = ~ck_nxt.level & ck_r.level;
        req_now = rq_r.level | ctrl_cal_r;
        wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & ack_r; // Lands with ack
    end

    // Calibration sequencer and result pipeline
    always_comb begin
        state_nxt = state_r;
        cal_cnt_nxt = cal_cnt_r;
        req_prev_nxt = req_now;
        fill_nxt = fill_r;
        out_nxt = out_r;
        dav_nxt = dav_r;
        cal_end = 1'b0;
        for (int i = 0; i < PD; i++) begin
            pipe_nxt[i] = pipe_r[i];
        end
        case (state_r)
            acop_pkg::ACOP_NORMAL: begin
                if (req_now & ~req_prev_r) begin
                    state_nxt = acop_pkg::ACOP_CALIB;
                    cal_cnt_nxt = '0;
                    fill_nxt = '0;
                end
            end
            acop_pkg::ACOP_CALIB: begin
                // Counts only real converter clock edges
                if (ck_rise) begin
                    if (cal_cnt_r == 15'(CAL_CYCLES - 1)) begin
                        state_nxt = acop_pkg::ACOP_NORMAL;
                        cal_end = 1'b1;
                    end else begin
                        cal_cnt_nxt = cal_cnt_r + 15'h1;
                    end
                end
            end
            default: state_nxt = acop_pkg::ACOP_NORMAL;
        endcase
        // One sample per converter clock, delivered four periods later
        if (ck_rise) begin
            pipe_nxt[0] = raw_word_i;
            for (int i = 1; i < PD; i++) begin
                pipe_nxt[i] = pipe_r[i-1];
            end
            if (state_r == acop_pkg::ACOP_NORMAL) begin
                out_nxt = pipe_r[PD-1];
                if (fill_r != 3'(PD)) begin
                    fill_nxt = fill_r + 3'h1;
                end
            end
            dav_nxt = 1'b0;
        end else if (ck_fall && state_r == acop_pkg::ACOP_NORMAL &&
                     fill_r == 3'(PD)) begin
            dav_nxt = 1'b1;
        end
        // Word clock parks low from the edge that enters calibration
        if (state_nxt == acop_pkg::ACOP_CALIB) begin
            dav_nxt = 1'b0;
        end
    end

    // Interrupt sources: calibration finished, over-range word delivered
    always_comb begin
        irq_set[`ACOP_IRQ_CAL_END_BIT] = cal_end;
        irq_set[`ACOP_IRQ_OVR_BIT] = ck_rise & out_nxt.over &
            (state_r == acop_pkg::ACOP_NORMAL);
    end

    // Wishbone slave: registered ack, a write lands at the acked edge
    always_comb begin
        ctrl_cal_nxt = ctrl_cal_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
        rdat_nxt = '0;
        if (wr_hit && wb_sel_i[0]) begin
            case (wb_adr_i)
                `ACOP_OFF_CTRL: ctrl_cal_nxt = wb_dat_i[`ACOP_CTRL_CAL_BIT];
                `ACOP_OFF_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~wb_dat_i[1:0];
                `ACOP_OFF_IRQ_MASK: irq_mask_nxt = wb_dat_i[1:0];
                default: ;
            endcase
        end
        irq_stat_nxt = irq_stat_nxt | irq_set; // Set wins over clear
        if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_r) begin
            case (wb_adr_i)
                `ACOP_OFF_CTRL: rdat_nxt[`ACOP_CTRL_CAL_BIT] = ctrl_cal_r;
                `ACOP_OFF_STAT: begin
                    rdat_nxt[`ACOP_STAT_CALIB_BIT] =
                        state_r == acop_pkg::ACOP_CALIB;
                    rdat_nxt[`ACOP_STAT_DONE_BIT] = cal_done_o;
                    rdat_nxt[`ACOP_STAT_FULL_BIT] = fill_r == 3'(PD);
                end
                `ACOP_OFF_IRQ_STAT: rdat_nxt[1:0] = irq_stat_r;
                `ACOP_OFF_IRQ_MASK: rdat_nxt[1:0] = irq_mask_r;
                `ACOP_OFF_LAST_WORD: rdat_nxt[`ACOP_LAST_OVR_BIT:0] = out_r;
                default: rdat_nxt = '0;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ck_r <= '0;
            rq_r <= '0;
            oe_r <= '0;
            state_r <= acop_pkg::ACOP_NORMAL;
            cal_cnt_r <= '0;
            fill_r <= '0;
            req_prev_r <= 1'b0;
            out_r <= '0;
            dav_r <= 1'b0;
            ctrl_cal_r <= `ACOP_CTRL_RST;
            irq_stat_r <= '0;
            irq_mask_r <= `ACOP_MASK_RST;
            ack_r <= 1'b0;
            rdat_r <= '0;
            for (int i = 0; i < PD; i++) begin
                pipe_r[i] <= '0;
            end
        end else begin
            ck_r <= ck_nxt;
            rq_r <= rq_nxt;
            oe_r <= oe_nxt;
            state_r <= state_nxt;
            cal_cnt_r <= cal_cnt_nxt;
            fill_r <= fill_nxt;
            req_prev_r <= req_prev_nxt;
            out_r <= out_nxt;
            dav_r <= dav_nxt;
            ctrl_cal_r <= ctrl_cal_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
            for (int i = 0; i < PD; i++) begin
                pipe_r[i] <= pipe_nxt[i];
            end
        end
    end

    // Output port; enables are low while the pins are driven
    always_comb begin
        sample_word_o = out_r.data;
        over_range_flag_o = out_r.over;
        sample_word_oe_n_o = {14{~oe_r.level}};
        over_range_flag_oe_n_o = ~oe_r.level;
        word_valid_clk_o = dav_r;
        cal_done_o = state_r == acop_pkg::ACOP_NORMAL;
        irq_o = |(irq_stat_r & irq_mask_r);
        wb_ack_o = ack_r;
        wb_dat_o = rdat_r;
    end

endmodule

// ---- test/acop_sva.sv ----
// Concurrent checks on the converter control block ports.
// Assumes binding to acop_top, everything on clk_i.
`timescale 1ns/10ps
module acop_sva #(
    parameter int CAL_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cal_request_i,
    input wire logic out_enable_i,
    input wire logic [13:0] sample_word_o,
    input wire logic [13:0] sample_word_oe_n_o,
    input wire logic over_range_flag_oe_n_o,
    input wire logic word_valid_clk_o,
    input wire logic cal_done_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Calibration steps: request rises in normal mode, then the run
    sequence s_req_rise;
        cal_done_o && !cal_request_i ##1 cal_request_i [*8];
    endsequence
    sequence s_in_cal;
        !cal_done_o [*2];
    endsequence
    a_cal_start: assert property (s_req_rise |=> !cal_done_o)
        else $error("calibration did not start");
    a_dav_in_cal: assert property (s_in_cal |-> !word_valid_clk_o)
        else $error("data valid clock active in calibration");
    a_float_same: assert property (
        sample_word_oe_n_o == {14{over_range_flag_oe_n_o}})
        else $error("port enables disagree");
    a_oe_on: assert property (
        out_enable_i [*6] |=> sample_word_oe_n_o == 14'h0000)
        else $error("port not driven");
    a_oe_off: assert property (
        !out_enable_i [*6] |=> over_range_flag_oe_n_o)
        else $error("port not floated");
    a_word_at_fall: assert property (
        $changed(sample_word_o) |-> !word_valid_clk_o)
        else $error("word changed while data valid clock high");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
endmodule

// ---- test/acop_capture.sv ----
// Converter clock source and word capture logic beyond the port.
// Assumes no pulls: a floated line reads back inverted.
`timescale 1ns/10ps
module acop_capture (
    output logic conv_clk_o,
    input wire logic word_valid_clk_i,
    input wire logic [13:0] word_i,
    input wire logic [13:0] word_oe_n_i,
    input wire logic over_i,
    input wire logic over_oe_n_i,
    output logic [14:0] held_o
);
    logic [14:0] pins;
    // Free-running clock, kept up through calibration
    initial begin
        conv_clk_o = 1'b0;
        forever #80 conv_clk_o = ~conv_clk_o;
    end
    // Line levels as seen by the capture side
    assign pins = {over_i ^ over_oe_n_i, word_i ^ word_oe_n_i};
    // Latch each word on the data-valid clock rising edge
    always @(posedge word_valid_clk_i) begin
        held_o <= pins;
    end
endmodule

// ---- test/acop_top_bench.sv ----
// Self-checking bench for acop_top with capture model and checker.
// Assumes acop_pkg, acop_sva and acop_capture compiled first.
`timescale 1ns/10ps
module acop_top_bench;
    logic clk_i, conv_clk_i, word_valid_clk_o, irq_o, wb_ack_o, cal_done_o;
    logic rst_i = 1'b1, cal_request_i = 1'b0, out_enable_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    acop_pkg::acop_word_t raw_word_i = 15'h0000;
    logic [13:0] sample_word_o, sample_word_oe_n_o;
    logic over_range_flag_o, over_range_flag_oe_n_o;
    logic [14:0] held;
    logic [14:0] last_w = 15'h0000, port_w;
    logic [3:0] sel_v = 4'hf;
    assign port_w = {over_range_flag_o, sample_word_o};
    logic [29:0] rows [3] = '{{2{15'h0001}}, {2{15'h7fff}}, {2{15'h2000}}};
    int n_mismatch, n_compared, cyc;
    acop_top #(.CAL_CYCLES(20)) acop_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .conv_clk_i(conv_clk_i), .cal_request_i(cal_request_i),
        .out_enable_i(out_enable_i), .raw_word_i(raw_word_i),
        .sample_word_o(sample_word_o),
        .sample_word_oe_n_o(sample_word_oe_n_o),
        .over_range_flag_o(over_range_flag_o),
        .over_range_flag_oe_n_o(over_range_flag_oe_n_o),
        .word_valid_clk_o(word_valid_clk_o), .cal_done_o(cal_done_o),
        .irq_o(irq_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    acop_capture acop_capture_inst (.conv_clk_o(conv_clk_i),
        .word_valid_clk_i(word_valid_clk_o), .word_i(sample_word_o),
        .word_oe_n_i(sample_word_oe_n_o), .over_i(over_range_flag_o),
        .over_oe_n_i(over_range_flag_oe_n_o), .held_o(held));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One classic bus cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [4:0] a,
                      input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel_v;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Cuts a hung run short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(sample_word_oe_n_o), 32'h3fff);
        check(32'(cal_done_o), 32'h1);
        wb(1'b1, 5'h0c, 32'h3);
        wb(1'b0, 5'h0c, 32'h0);
        check(q, 32'h3);
        // A write with its low byte lane off leaves the mask alone
        sel_v = 4'h0;
        wb(1'b1, 5'h0c, 32'h0);
        sel_v = 4'hf;
        wb(1'b0, 5'h0c, 32'h0);
        check(q, 32'h3);
        wb(1'b0, 5'h14, 32'h0);
        check(q, 32'h0);
        out_enable_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(32'(sample_word_oe_n_o), 32'h0);
        // Each row: old word until the fourth rise, then the new one
        for (int i = 0; i < 3; i++) begin
            @(posedge conv_clk_i);
            @(posedge clk_i);
            raw_word_i <= rows[i][29:15];
            repeat (4) @(posedge conv_clk_i);
            check(32'(port_w), 32'(last_w));
            repeat (16) @(posedge clk_i);
            check(32'(port_w), 32'(rows[i][14:0]));
            check(32'(held), 32'(rows[i][14:0]));
            last_w = rows[i][14:0];
        end
        check(32'(irq_o), 32'h1);
        wb(1'b0, 5'h10, 32'h0);
        check(q, 32'h2000);
        wb(1'b0, 5'h04, 32'h0);
        check(q, 32'h6);
        wb(1'b1, 5'h08, 32'h2);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        cal_request_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check(32'(cal_done_o), 32'h0);
        cal_request_i <= 1'b0;
        repeat (290) @(posedge clk_i);
        check(32'(cal_done_o), 32'h0);
        repeat (60) @(posedge clk_i);
        check(32'(cal_done_o), 32'h1);
        check(32'(irq_o), 32'h1);
        // Software request through the control register
        wb(1'b1, 5'h08, 32'h1);
        wb(1'b1, 5'h00, 32'h1);
        wb(1'b0, 5'h04, 32'h0);
        check(q, 32'h1);
        wb(1'b1, 5'h00, 32'h0);
        check(32'(irq_o), 32'h0);
        repeat (360) @(posedge clk_i);
        check(32'(cal_done_o), 32'h1);
        check(32'(irq_o), 32'h1);
        out_enable_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        check(32'(over_range_flag_oe_n_o), 32'h1);
        check(32'(sample_word_oe_n_o), 32'h3fff);
        // Mid-run reset brings the port back to its idle values
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(32'(sample_word_o), 32'h0);
        check(32'(irq_o), 32'h0);
        check(32'(cal_done_o), 32'h1);
        conclude();
    end
endmodule
bind acop_top acop_sva #(.CAL_CYCLES(CAL_CYCLES)) acop_sva_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cal_request_i(cal_request_i),
    .out_enable_i(out_enable_i), .sample_word_o(sample_word_o),
    .sample_word_oe_n_o(sample_word_oe_n_o),
    .over_range_flag_oe_n_o(over_range_flag_oe_n_o),
    .word_valid_clk_o(word_valid_clk_o), .cal_done_o(cal_done_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
